// ### shared/flash_pkg.sv
package flash_pkg;
   localparam logic [7:0] OP_SMALL = 8'h20;
   localparam logic [7:0] OP_B32 = 8'h52;
   localparam logic [7:0] OP_B64 = 8'hd8;
   localparam logic [7:0] OP_CHIP_A = 8'h60;
   localparam logic [7:0] OP_CHIP_B = 8'hc7;
   localparam logic [7:0] OP_PAGE = 8'h02;
   localparam logic [7:0] OP_DUAL = 8'ha2;
   localparam logic [7:0] OP_QUAD = 8'h32;
   localparam logic [7:0] OP_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_STATUS = 8'h05;
   localparam logic [7:0] ERASED = 8'hff;
   localparam logic [23:0] SPAN_SMALL = 24'h00_0fff;
   localparam logic [23:0] SPAN_B32 = 24'h00_7fff;
   localparam logic [23:0] SPAN_B64 = 24'h00_ffff;
   localparam logic [23:0] SPAN_PAGE = 24'h00_00ff;
   localparam logic [23:0] SPAN_CHIP = 24'hff_ffff;
   localparam int SECT_SHIFT = 12;
   localparam int PAGE_BYTES = 256;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [1:0] ADDR_LAST = 2'h2;
   localparam int ST_BUSY = 0;
   localparam int ST_LATCH = 1;
   localparam int ST_PROT_LSB = 2;
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0c;
   localparam int CMD_ADDR_EN = 8;
   localparam int CMD_LANES_LSB = 9;
   localparam int CMD_READ_EN = 11;
   localparam int CMD_EXTRA_LSB = 12;
   localparam int CMD_LEN_LSB = 16;
   localparam logic [5:0] HEAD_UNITS_ADDR = 6'h20;
   localparam logic [5:0] HEAD_UNITS_CMD = 6'h08;
   localparam logic [5:0] READ_UNITS = 6'h08;
   localparam int DIV_HALF_DEF = 4;
   typedef enum logic [1:0] {LANE_1, LANE_2, LANE_4} lanes_t;
endpackage : flash_pkg

// ### shared/spi_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
   logic cs_n;
   logic sclk;
   logic [3:0] host_o;
   logic [3:0] host_oe;
   logic [3:0] dev_o;
   logic [3:0] dev_oe;
   logic [3:0] dq;
   // undriven lines float high, as with a pull-up
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         dq[i] = host_oe[i] ? host_o[i] : (dev_oe[i] ? dev_o[i] : 1'b1);
      end
   end
   modport host_end(output cs_n, output sclk, output host_o, output host_oe, input dq);
   modport dev_end(input cs_n, input sclk, input dq, output dev_o, output dev_oe);
endinterface : spi_link_if
`default_nettype wire

// ### verilog/flash_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - 20h plus address clears one 4K sector
// - 52h plus address clears one 32K block
// - d8h plus address clears one 64K block
// - 60h or c7h clears whole array
// - erase and program need write latch set
// - erase frame must end on byte boundary
// - busy during self-timed cycle, latch cleared after
// - status reads answered while busy
// - protected region is not erased or programmed
// - protected 32K block: no change, latch cleared
// - whole clear only with no protection
// - single-line forms ignore upper data lines
// - 02h programs bits toward zero in page
// - page data wraps inside the same page
// - only last 256 bytes are kept
// - unsent page bytes stay unchanged
// - program frame must end on byte boundary
// - a2h takes data two bits per clock
// - 32h takes four bits, needs quad permit
// - quad permit must read one
module flash_dev #(
   parameter int MEM_AW = 16,
   parameter int SMALL_CLEAR_CYC = 64,
   parameter int BLOCK32_CLEAR_CYC = 128,
   parameter int BLOCK64_CLEAR_CYC = 256,
   parameter int WHOLE_CLEAR_CYC = 512,
   parameter int PAGE_WRITE_CYC = 32
) (
   input wire logic clock,
   input wire logic arst_n,
   spi_link_if.dev_end link,
   input wire logic [4:0] protect_level,
   input wire logic quad_io_permit,
   input wire logic [MEM_AW-1:0] peek_addr,
   output logic [7:0] peek_data,
   output logic op_in_flight,
   output logic write_latch
);
   import flash_pkg::*;

   typedef enum logic [2:0] {D_CMD, D_ADDR, D_DATA, D_STATUS, D_DONE, D_IGNORE} dstate_t;
   localparam int SECT_COUNT = 2 ** (MEM_AW - SECT_SHIFT);

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; third stage only feeds edge detection
   logic [2:0] cs_sync_ff;
   logic [2:0] sck_sync_ff;
   logic [3:0] dq_meta_ff;
   logic [3:0] dq_sync_ff;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic cs_high;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cs_sync_ff <= '1;
         sck_sync_ff <= '0;
         dq_meta_ff <= '0;
         dq_sync_ff <= '0;
      end else begin
         cs_sync_ff <= {cs_sync_ff[1:0], link.cs_n};
         sck_sync_ff <= {sck_sync_ff[1:0], link.sclk};
         dq_meta_ff <= link.dq;
         dq_sync_ff <= dq_meta_ff;
      end
   end

   assign sck_rise = sck_sync_ff[1] & ~sck_sync_ff[2];
   assign sck_fall = ~sck_sync_ff[1] & sck_sync_ff[2];
   assign cs_rise = cs_sync_ff[1] & ~cs_sync_ff[2];
   assign cs_high = cs_sync_ff[1];

   ////////////////////////////////////////////////////////////////////////////////
   // frame decoding
   dstate_t st_ff;
   dstate_t dec_st;
   lanes_t lanes_ff;
   lanes_t dec_lanes;
   logic [7:0] op_ff;
   logic [7:0] sh_ff;
   logic [3:0] nb_ff;
   logic [1:0] ab_ff;
   logic [23:0] addr_ff;
   logic seen_ff;
   logic [7:0] ptr_ff;
   logic [7:0] nxt_sh;
   logic [3:0] nxt_nb;
   logic [3:0] step;
   logic byte_done;
   logic op_is_prog;
   logic busy_ff;
   logic latch_ff;

   always_comb begin
      nxt_sh = {sh_ff[6:0], dq_sync_ff[0]}; // upper lines unread here
      step = 4'h1;
      if (st_ff == D_DATA && lanes_ff == LANE_2) begin
         nxt_sh = {sh_ff[5:0], dq_sync_ff[1:0]}; // line 1 holds the higher bit
         step = 4'h2;
      end
      if (st_ff == D_DATA && lanes_ff == LANE_4) begin
         nxt_sh = {sh_ff[3:0], dq_sync_ff[3:0]};
         step = 4'h4;
      end
      nxt_nb = nb_ff + step;
      byte_done = nxt_nb == BYTE_BITS;
   end

   always_comb begin
      dec_st = D_IGNORE;
      dec_lanes = LANE_1;
      if (nxt_sh == OP_STATUS) begin
         dec_st = D_STATUS;
      end else if (!busy_ff) begin
         case (nxt_sh)
            OP_LATCH_SET: dec_st = D_DONE;
            OP_SMALL, OP_B32, OP_B64: begin
               if (latch_ff) dec_st = D_ADDR;
            end
            OP_CHIP_A, OP_CHIP_B: begin
               if (latch_ff) dec_st = D_DONE;
            end
            OP_PAGE: begin
               if (latch_ff) dec_st = D_ADDR;
            end
            OP_DUAL: begin
               if (latch_ff) begin
                  dec_st = D_ADDR;
                  dec_lanes = LANE_2;
               end
            end
            OP_QUAD: begin
               if (latch_ff && quad_io_permit) begin
                  dec_st = D_ADDR;
                  dec_lanes = LANE_4;
               end
            end
            default: dec_st = D_IGNORE;
         endcase
      end
   end

   assign op_is_prog = op_ff == OP_PAGE || op_ff == OP_DUAL || op_ff == OP_QUAD;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= D_CMD;
         lanes_ff <= LANE_1;
         op_ff <= '0;
         sh_ff <= '0;
         nb_ff <= '0;
         ab_ff <= '0;
         addr_ff <= '0;
         seen_ff <= 1'b0;
         ptr_ff <= '0;
      end else if (cs_high) begin
         st_ff <= D_CMD;
         nb_ff <= '0;
         ab_ff <= '0;
         seen_ff <= 1'b0;
      end else if (sck_rise) begin
         sh_ff <= nxt_sh;
         nb_ff <= byte_done ? 4'h0 : nxt_nb;
         if (st_ff == D_DONE) begin
            st_ff <= D_IGNORE; // any bit past the final byte kills the erase
         end else if (byte_done) begin
            unique case (st_ff)
               D_CMD: begin
                  op_ff <= nxt_sh;
                  st_ff <= dec_st;
                  lanes_ff <= dec_lanes;
               end
               D_ADDR: begin
                  addr_ff <= {addr_ff[15:0], nxt_sh};
                  ab_ff <= ab_ff + 2'h1;
                  if (ab_ff == ADDR_LAST) begin
                     st_ff <= op_is_prog ? D_DATA : D_DONE;
                     ptr_ff <= nxt_sh; // start offset inside the page
                  end
               end
               D_DATA: begin
                  ptr_ff <= ptr_ff + 8'h01; // 8-bit offset wraps in page
                  seen_ff <= 1'b1;
               end
               D_STATUS, D_DONE, D_IGNORE: begin
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // page buffer; later bytes overwrite earlier ones at the same offset
   logic [7:0] pbuf_ff [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] mask_ff;
   logic data_byte;

   assign data_byte = sck_rise && !cs_high && byte_done && st_ff == D_DATA;

   always_ff @(posedge clock) begin
      if (data_byte) pbuf_ff[ptr_ff] <= nxt_sh; // last 256 survive
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mask_ff <= '0;
      end else if (sck_rise && !cs_high && byte_done && st_ff == D_CMD && !busy_ff) begin // walk reads it
         mask_ff <= '0;
      end else if (data_byte) begin
         mask_ff[ptr_ff] <= 1'b1; // only sent offsets change
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // start of the self-timed cycle at chip select release
   logic [23:0] span;
   logic [31:0] cyc;
   logic [MEM_AW-1:0] lo;
   logic [MEM_AW-1:0] hi;
   logic [7:0] hsum;
   logic prot;
   logic go_cmd;
   logic go_data;

   always_comb begin
      span = SPAN_SMALL;
      cyc = 32'(SMALL_CLEAR_CYC);
      case (op_ff)
         OP_B32: begin
            span = SPAN_B32;
            cyc = 32'(BLOCK32_CLEAR_CYC);
         end
         OP_B64: begin
            span = SPAN_B64;
            cyc = 32'(BLOCK64_CLEAR_CYC);
         end
         OP_CHIP_A, OP_CHIP_B: begin
            span = SPAN_CHIP;
            cyc = 32'(WHOLE_CLEAR_CYC);
         end
         OP_PAGE, OP_DUAL, OP_QUAD: begin
            span = SPAN_PAGE;
            cyc = 32'(PAGE_WRITE_CYC);
         end
         default: begin
         end
      endcase
      lo = addr_ff[MEM_AW-1:0] & ~span[MEM_AW-1:0]; // any address in the unit
      hi = addr_ff[MEM_AW-1:0] | span[MEM_AW-1:0];
      // top sectors are protected; the whole span hits them when its top does
      hsum = 8'(hi >> SECT_SHIFT) + 8'(protect_level);
      prot = protect_level != '0 && hsum >= 8'(SECT_COUNT);
   end

   assign go_cmd = cs_rise && st_ff == D_DONE && op_ff != OP_LATCH_SET;
   assign go_data = cs_rise && st_ff == D_DATA && nb_ff == '0 && seen_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // busy, latch and array walk
   logic [MEM_AW-1:0] wp_ff;
   logic [MEM_AW-1:0] whi_ff;
   logic [31:0] tmr_ff;
   logic prog_ff;
   logic walk_ff;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         busy_ff <= 1'b0;
         latch_ff <= 1'b0;
         wp_ff <= '0;
         whi_ff <= '0;
         tmr_ff <= '0;
         prog_ff <= 1'b0;
         walk_ff <= 1'b0;
      end else if (cs_rise && st_ff == D_DONE && op_ff == OP_LATCH_SET) begin
         latch_ff <= 1'b1;
      end else if (go_cmd || go_data) begin
         if (!prot) begin
            busy_ff <= 1'b1;
            wp_ff <= lo;
            whi_ff <= hi;
            tmr_ff <= cyc;
            prog_ff <= go_data;
            walk_ff <= 1'b1;
         end else if (op_ff == OP_B32) begin
            latch_ff <= 1'b0;
         end
      end else if (busy_ff) begin
         if (walk_ff) begin
            wp_ff <= wp_ff + MEM_AW'(1);
            if (wp_ff == whi_ff) walk_ff <= 1'b0;
         end
         if (tmr_ff != '0) begin
            tmr_ff <= tmr_ff - 32'h0000_0001;
         end else if (!walk_ff) begin
            busy_ff <= 1'b0;
            latch_ff <= 1'b0;
         end
      end
   end

   // contents start undefined: clear the array before relying on it
   logic [7:0] mem_ff [2**MEM_AW];

   always_ff @(posedge clock) begin
      if (busy_ff && walk_ff) begin
         if (!prog_ff) begin
            mem_ff[wp_ff] <= ERASED;
         end else if (mask_ff[wp_ff[7:0]]) begin
            mem_ff[wp_ff] <= mem_ff[wp_ff] & pbuf_ff[wp_ff[7:0]];
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) peek_data <= '0;
      else peek_data <= mem_ff[peek_addr];
   end

   assign op_in_flight = busy_ff;
   assign write_latch = latch_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // status answer on line 1, live value repeated every byte
   logic [7:0] stat;
   logic [2:0] scnt_ff;
   logic [3:0] dout_ff;
   logic [3:0] doe_ff;

   always_comb begin
      stat = '0;
      stat[ST_BUSY] = busy_ff;
      stat[ST_LATCH] = latch_ff;
      stat[ST_PROT_LSB +: 5] = protect_level;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         scnt_ff <= '0;
         dout_ff <= '0;
         doe_ff <= '0;
      end else if (cs_high) begin
         scnt_ff <= '0;
         doe_ff <= '0;
      end else if (st_ff == D_STATUS && sck_fall) begin
         doe_ff[1] <= 1'b1;
         dout_ff[1] <= stat[~scnt_ff];
         scnt_ff <= scnt_ff + 3'h1;
      end
   end

   assign link.dev_o = dout_ff;
   assign link.dev_oe = doe_ff;
endmodule : flash_dev
`default_nettype wire

// ### verilog/flash_host.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host #(
   parameter int DIV_HALF = flash_pkg::DIV_HALF_DEF,
   parameter int HBUF = 512
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   spi_link_if.host_end link
);
   import flash_pkg::*;

   typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL} hstate_t;
   typedef enum logic [1:0] {S_HEAD, S_DATA, S_EXTRA, S_READ} seg_t;

   hstate_t hs_ff;
   seg_t seg_ff;
   logic [31:0] cmd_ff;
   logic [23:0] haddr_ff;
   logic [7:0] hbuf_ff [HBUF];
   logic [$clog2(HBUF)-1:0] widx_ff;
   logic [$clog2(HBUF)-1:0] ridx_ff;
   logic [8:0] len_ff;
   logic [31:0] sh_ff;
   logic [5:0] cnt_ff;
   logic [7:0] div_ff;
   logic [7:0] rx_ff;
   logic [3:0] dq_meta_ff;
   logic [3:0] dq_sync_ff;
   logic acc;
   logic start;
   lanes_t lanes;

   ////////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, write lands on the pready edge
   assign acc = psel && penable && pready;
   assign start = acc && pwrite && paddr == REG_CMD && hs_ff == H_IDLE;
   assign lanes = lanes_t'(cmd_ff[CMD_LANES_LSB +: 2]);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
         cmd_ff <= '0;
         haddr_ff <= '0;
      end else begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready) begin
            unique case (paddr)
               REG_CMD: prdata <= cmd_ff;
               REG_ADDR: prdata <= 32'(haddr_ff);
               REG_STAT: prdata <= {16'h0000, rx_ff, 7'h00, hs_ff != H_IDLE};
               default: prdata <= '0;
            endcase
         end
         if (start) cmd_ff <= pwdata;
         if (acc && pwrite && paddr == REG_ADDR) haddr_ff <= pwdata[23:0];
      end
   end

   always_ff @(posedge clock) begin
      if (acc && pwrite && paddr == REG_DATA) hbuf_ff[widx_ff] <= pwdata[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // serial engine, mode 0: drive while low, device samples on the rise
   logic [5:0] units;
   logic [5:0] nxt_cnt;
   logic [31:0] nxt_sh;
   seg_t nxt_seg;
   logic fin;

   always_comb begin
      units = 6'h08;
      if (lanes == LANE_2) units = 6'h04;
      if (lanes == LANE_4) units = 6'h02;
      nxt_seg = S_READ;
      nxt_cnt = READ_UNITS;
      nxt_sh = '0;
      fin = 1'b0;
      if (len_ff != '0 && (seg_ff == S_HEAD || seg_ff == S_DATA)) begin
         nxt_seg = S_DATA;
         nxt_cnt = units;
         nxt_sh = {hbuf_ff[ridx_ff], 24'h00_0000};
      end else if (seg_ff != S_EXTRA && seg_ff != S_READ && cmd_ff[CMD_EXTRA_LSB +: 3] != '0) begin
         nxt_seg = S_EXTRA;
         nxt_cnt = 6'(cmd_ff[CMD_EXTRA_LSB +: 3]);
      end else if (seg_ff == S_READ || !cmd_ff[CMD_READ_EN]) begin
         fin = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dq_meta_ff <= '0;
         dq_sync_ff <= '0;
      end else begin
         dq_meta_ff <= link.dq;
         dq_sync_ff <= dq_meta_ff;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         hs_ff <= H_IDLE;
         seg_ff <= S_HEAD;
         widx_ff <= '0;
         ridx_ff <= '0;
         len_ff <= '0;
         sh_ff <= '0;
         cnt_ff <= '0;
         div_ff <= '0;
         rx_ff <= '0;
      end else begin
         if (acc && pwrite && paddr == REG_DATA) widx_ff <= widx_ff + ($clog2(HBUF))'(1);
         div_ff <= div_ff + 8'h01;
         unique case (hs_ff)
            H_IDLE: begin
               div_ff <= '0;
               if (start) begin
                  hs_ff <= H_LOW;
                  seg_ff <= S_HEAD;
                  ridx_ff <= '0;
                  len_ff <= pwdata[CMD_LEN_LSB +: 9];
                  sh_ff <= pwdata[CMD_ADDR_EN] ? {pwdata[7:0], haddr_ff} : {pwdata[7:0], 24'h00_0000};
                  cnt_ff <= pwdata[CMD_ADDR_EN] ? HEAD_UNITS_ADDR : HEAD_UNITS_CMD;
               end
            end
            H_LOW: begin
               if (div_ff == 8'(DIV_HALF - 1)) begin
                  hs_ff <= H_HIGH;
                  div_ff <= '0;
               end
            end
            H_HIGH: begin
               if (div_ff == 8'(DIV_HALF - 1)) begin
                  div_ff <= '0;
                  hs_ff <= H_LOW;
                  if (seg_ff == S_READ) rx_ff <= {rx_ff[6:0], dq_sync_ff[1]};
                  if (cnt_ff != 6'h01) begin
                     cnt_ff <= cnt_ff - 6'h01;
                     if (seg_ff == S_DATA && lanes == LANE_4) sh_ff <= sh_ff << 4;
                     else if (seg_ff == S_DATA && lanes == LANE_2) sh_ff <= sh_ff << 2;
                     else sh_ff <= sh_ff << 1;
                  end else if (fin) begin
                     hs_ff <= H_TAIL;
                  end else begin
                     seg_ff <= nxt_seg;
                     cnt_ff <= nxt_cnt;
                     sh_ff <= nxt_sh;
                     if (nxt_seg == S_DATA) begin
                        ridx_ff <= ridx_ff + ($clog2(HBUF))'(1);
                        len_ff <= len_ff - 9'h001;
                     end
                  end
               end
            end
            H_TAIL: begin
               if (div_ff == 8'(DIV_HALF - 1)) begin
                  hs_ff <= H_IDLE;
                  widx_ff <= '0;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pins; single-line segments drive line 0 only
   logic cs_n_ff;
   logic sclk_ff;
   logic [3:0] dqo_ff;
   logic [3:0] dqoe_ff;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cs_n_ff <= 1'b1;
         sclk_ff <= 1'b0;
         dqo_ff <= '0;
         dqoe_ff <= '0;
      end else begin
         cs_n_ff <= hs_ff == H_IDLE || hs_ff == H_TAIL;
         sclk_ff <= hs_ff == H_HIGH;
         dqo_ff <= {3'b000, sh_ff[31]};
         dqoe_ff <= (hs_ff == H_LOW || hs_ff == H_HIGH) && seg_ff != S_READ ? 4'h1 : 4'h0;
         if (seg_ff == S_DATA && lanes == LANE_2) begin
            dqo_ff <= {2'b00, sh_ff[31:30]};
            dqoe_ff <= 4'h3;
         end
         if (seg_ff == S_DATA && lanes == LANE_4) begin
            dqo_ff <= sh_ff[31:28];
            dqoe_ff <= 4'hf;
         end
      end
   end

   assign link.cs_n = cs_n_ff;
   assign link.sclk = sclk_ff;
   assign link.host_o = dqo_ff;
   assign link.host_oe = dqoe_ff;
endmodule : flash_host
`default_nettype wire

// ### dv/flash_erase_program_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module flash_erase_program_seq_properties (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [3:0] host_o,
   input wire logic [3:0] host_oe,
   input wire logic [3:0] dev_oe,
   input wire logic op_in_flight,
   input wire logic write_latch
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // one bit cell: high half of four clocks, then low again
   sequence high_half;
      sclk [*4] ##1 !sclk;
   endsequence
   a_sclk_half_width: assert property ($rose(sclk) |-> high_half)
      else $error("serial clock high half has wrong length");
   a_data_steady_high: assert property (sclk && $past(sclk) |-> $stable(host_o & host_oe))
      else $error("host data moved while serial clock high");
   a_idle_clock_low: assert property (cs_n |-> !sclk)
      else $error("serial clock high outside a frame");
   a_cs_gap_held: assert property ($rose(cs_n) |=> cs_n)
      else $error("chip select gap shorter than two clocks");
   a_no_line_fight: assert property ((host_oe & dev_oe) == 4'h0)
      else $error("host and device drive the same line");
   a_dev_line_one: assert property (dev_oe[3:2] == 2'h0 && !dev_oe[0])
      else $error("device drives a line other than line one");
   a_opcode_one_line: assert property ($fell(cs_n) |-> host_oe[3:1] == 3'h0)
      else $error("opcode not sent on a single line");
   // busy may only start once chip select has been high a while
   a_busy_after_cs: assert property ($rose(op_in_flight) |-> cs_n && $past(cs_n, 2))
      else $error("busy rose without chip select high");
   a_busy_needs_latch: assert property ($rose(op_in_flight) |-> $past(write_latch))
      else $error("busy rose while write latch clear");
   a_latch_cleared_end: assert property ($fell(op_in_flight) |-> ##[0:2] !write_latch)
      else $error("write latch not cleared at end of cycle");
endmodule : flash_erase_program_seq_properties
`default_nettype wire

// ### dv/flash_erase_program_seq_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_erase_program_seq_tb;
   import flash_pkg::*;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, quad_io_permit = 1'b0;
   logic pready, op_in_flight, write_latch;
   logic [7:0] paddr = 8'h00, peek_data, st;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [4:0] protect_level = 5'h00;
   logic [11:0] peek_addr = 12'h000;
   int mismatches = 0, n_compared = 0, cycles = 0;
   spi_link_if link();
   flash_host flash_host_inst (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr(), .link(link.host_end));
   // small array keeps each erase short; one sector means any nonzero protect level covers all
   flash_dev #(.MEM_AW(12)) flash_dev_inst (.clock, .arst_n, .link(link.dev_end),
      .protect_level, .quad_io_permit, .peek_addr, .peek_data, .op_in_flight, .write_latch);
   flash_erase_program_seq_properties flash_erase_program_seq_properties_inst (.clock,
      .arst_n, .cs_n(link.cs_n), .sclk(link.sclk), .host_o(link.host_o),
      .host_oe(link.host_oe), .dev_oe(link.dev_oe), .op_in_flight, .write_latch);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      if (mismatches == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // byte i carries b0 + i + i/256 so bytes 256 apart still differ
   task automatic frame(input logic [7:0] op, input logic [31:0] fl, input logic [23:0] a,
         input int n, input logic [7:0] b0);
      for (int i = 0; i < n; i++) begin
         apb(1'b1, REG_DATA, {24'h00_0000, b0 + 8'(i + i / 256)});
      end
      apb(1'b1, REG_ADDR, {8'h00, a});
      apb(1'b1, REG_CMD, fl | {7'h00, 9'(n), 8'h00, op});
      do apb(1'b0, REG_STAT, 32'h0000_0000); while (rd[0] !== 1'b0);
   endtask : frame
   task automatic status();
      frame(OP_STATUS, 32'h0000_0800, 24'h00_0000, 0, 8'h00);
      apb(1'b0, REG_STAT, 32'h0000_0000);
      st = rd[15:8];
   endtask : status
   task automatic settle();
      do status(); while (st[0] !== 1'b0);
   endtask : settle
   task automatic latch();
      frame(OP_LATCH_SET, 32'h0000_0000, 24'h00_0000, 0, 8'h00);
   endtask : latch
   task automatic mem(input logic [11:0] a, input logic [7:0] exp);
      peek_addr <= a;
      repeat (2) @(posedge clock);
      chk(peek_data, exp);
   endtask : mem
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_chip(input logic [7:0] op);
      latch();
      status();
      chk(st, 8'h02);
      frame(op, 32'h0000_0000, 24'h00_0000, 0, 8'h00);
      status();
      chk(st, 8'h03);
      settle();
      chk(st, 8'h00);
      mem(12'h123, ERASED);
      mem(12'hfff, ERASED);
   endtask : t_chip
   task automatic t_page();
      frame(OP_PAGE, 32'h0000_0100, 24'h00_0010, 1, 8'h3c);
      status();
      chk(st, 8'h00);
      mem(12'h010, ERASED);
      latch();
      frame(OP_PAGE, 32'h0000_0100, 24'h00_01fe, 3, 8'h11);
      settle();
      mem(12'h1ff, 8'h12);
      mem(12'h100, 8'h13);
      mem(12'h101, ERASED);
      latch();
      frame(OP_PAGE, 32'h0000_0100, 24'h00_0600, 258, 8'h00);
      settle();
      mem(12'h600, 8'h01);
      mem(12'h601, 8'h02);
   endtask : t_page
   task automatic t_lanes();
      latch();
      frame(OP_DUAL, 32'h0000_0300, 24'h00_0200, 1, 8'ha5);
      settle();
      mem(12'h200, 8'ha5);
      latch();
      frame(OP_QUAD, 32'h0000_0500, 24'h00_0300, 1, 8'h5a);
      status();
      chk(st & 8'h01, 8'h00);
      mem(12'h300, ERASED);
      quad_io_permit <= 1'b1;
      latch();
      frame(OP_QUAD, 32'h0000_0500, 24'h00_0300, 1, 8'h5a);
      settle();
      mem(12'h300, 8'h5a);
   endtask : t_lanes
   task automatic t_guard();
      protect_level <= 5'h01;
      latch();
      frame(OP_PAGE, 32'h0000_0100, 24'h00_0400, 1, 8'h00);
      status();
      chk(st, 8'h06);
      mem(12'h400, ERASED);
      frame(OP_B32, 32'h0000_0100, 24'h00_0000, 0, 8'h00);
      status();
      chk(st, 8'h04);
      latch();
      frame(OP_CHIP_A, 32'h0000_0000, 24'h00_0000, 0, 8'h00);
      mem(12'h1fe, 8'h11);
      protect_level <= 5'h00;
      latch();
      frame(OP_PAGE, 32'h0000_1100, 24'h00_0500, 1, 8'h00);
      mem(12'h500, ERASED);
      frame(OP_SMALL, 32'h0000_1100, 24'h00_0abc, 0, 8'h00);
      status();
      chk(st & 8'h01, 8'h00);
      mem(12'h1fe, 8'h11);
   endtask : t_guard
   task automatic t_erase(input logic [7:0] op);
      latch();
      frame(OP_PAGE, 32'h0000_0100, 24'h00_0700, 1, 8'h77);
      settle();
      latch();
      frame(op, 32'h0000_0100, 24'h00_0abc, 0, 8'h00);
      settle();
      mem(12'h700, ERASED);
   endtask : t_erase
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 95000) begin
         mismatches++;
         summarize();
      end
   end
   initial begin
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      t_chip(OP_CHIP_B);
      t_chip(OP_CHIP_A);
      t_page();
      t_lanes();
      t_guard();
      t_erase(OP_SMALL);
      t_erase(OP_B32);
      t_erase(OP_B64);
      summarize();
   end
endmodule : flash_erase_program_seq_tb
`default_nettype wire
